/* cis_defs.svh */
// constants of the command identifier and status word codec
// assumes byte addresses on a 32-bit register port
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH

// status word fields
`define CIS_CODE_LSB      0
`define CIS_CODE_W        12
`define CIS_RSVD_BIT      12
`define CIS_NS_LSB        13
`define CIS_NS_W          2
`define CIS_SEV_BIT       15
`define CIS_NS_PROTOCOL   2'h0
`define CIS_NS_TECH       2'h1
`define CIS_NS_DEVICE     2'h2

// status codes
`define CIS_STATUS_OK              16'h0000
`define CIS_STATUS_UNSUPPORTED_CMD 16'h8001
`define CIS_STATUS_BAD_PARAM       16'h8002
`define CIS_STATUS_NO_SUCH_ADDR    16'h8003
`define CIS_STATUS_READ_ONLY       16'h8004
`define CIS_STATUS_MISALIGNED      16'h8005
`define CIS_STATUS_NO_ACCESS       16'h8006
`define CIS_STATUS_RECV_OCCUPIED   16'h8007
`define CIS_STATUS_REPLY_TIMEOUT   16'h800b
`define CIS_STATUS_BAD_HEADER      16'h800e
`define CIS_STATUS_CONFIG_FORBIDS  16'h800f
`define CIS_STATUS_GENERIC_FAIL    16'h8fff

// opcode word fields and standard values
`define CIS_ACK_BIT        0
`define CIS_CUSTOM_BIT     15
`define CIS_MEM_READ_REQ   16'h0800
`define CIS_MEM_READ_REP   16'h0801
`define CIS_MEM_WRITE_REQ  16'h0802
`define CIS_MEM_WRITE_REP  16'h0803
`define CIS_PENDING_REP    16'h0805
`define CIS_EVENT_REQ      16'h0c00
`define CIS_EVENT_REP      16'h0c01

// header sizes in bytes
`define CIS_HDR_BYTES      16'h0008
`define CIS_READ_SCD_BYTES 16'h000c
`define CIS_ADDR_BYTES     16'h0008
`define CIS_FLAG_RSVD_MASK 16'h3fff

// register byte addresses
`define CIS_REG_CTRL     8'h00
`define CIS_REG_HDR_IN0  8'h04
`define CIS_REG_HDR_IN1  8'h08
`define CIS_REG_PKT_INFO 8'h0c
`define CIS_REG_COND     8'h10
`define CIS_REG_EXT_STAT 8'h14
`define CIS_REG_ACK_HDR0 8'h18
`define CIS_REG_ACK_HDR1 8'h1c
`define CIS_REG_STAT     8'h20

// control and condition bits
`define CIS_CTRL_GO        0
`define CIS_CTRL_CLR_TMO   1
`define CIS_CTRL_CUSTOM_EN 2
`define CIS_COND_W         10
`define CIS_EXT_EN_BIT     15

`endif

/* cis_pkg.sv */
// types of the command identifier and status word codec
// assumes cis_defs.svh supplies the numeric constants
package cis_pkg;

  typedef enum logic [2:0] {
    CIS_IDLE = 3'h1,
    CIS_EVAL = 3'h2,
    CIS_DONE = 3'h4
  } cis_state_type;

  // one-hot kind of a received opcode word
  typedef enum logic [3:0] {
    CIS_KIND_NONE  = 4'h0,
    CIS_KIND_READ  = 4'h1,
    CIS_KIND_WRITE = 4'h2,
    CIS_KIND_EVENT = 4'h4,
    CIS_KIND_OTHER = 4'h8
  } cis_kind_type;

  typedef struct packed {
    logic generic_fail;
    logic warn;
    logic reserved_nonzero;
    logic config_forbids;
    logic busy;
    logic no_write;
    logic no_read;
    logic misaligned;
    logic read_only;
    logic addr_missing;
  } cis_cond_type;

endpackage

/* cis_cls_if.sv */
// carrier between the register front end and the classifier
// assumes one clock domain; all signals are plain levels
`timescale 1ns/100ps
interface cis_cls_if;
  import cis_pkg::*;
  logic [15:0]  flags;
  logic [15:0]  opcode_word;
  logic [15:0]  length;
  logic [15:0]  transaction_seq;
  logic [15:0]  pkt_size;
  logic [7:0]   frame_ovh;
  logic         custom_en;
  cis_cond_type cond;
  logic [15:0]  ext_status;
  logic [15:0]  status;
  logic [15:0]  ack_opcode;
  logic         is_ack;
  logic         is_custom;
  cis_kind_type kind;

  modport ctl (output flags, opcode_word, length, transaction_seq,
               pkt_size, frame_ovh, custom_en, cond, ext_status,
               input status, ack_opcode, is_ack, is_custom, kind);
  modport cls (input flags, opcode_word, length, transaction_seq,
               pkt_size, frame_ovh, custom_en, cond, ext_status,
               output status, ack_opcode, is_ack, is_custom, kind);
endinterface // cis_cls_if

/* cis_classifier.sv */
// combinational decode of an opcode word and choice of status word
// assumes header fields are held stable by the front end
`timescale 1ns/100ps
`include "cis_defs.svh"
module cis_classifier
  import cis_pkg::*;
(
  cis_cls_if.cls bus
);

  // assemble a status word; reserved bit always zero
  function automatic logic [15:0] cis_make_status(
    input logic [11:0] code,
    input logic [1:0]  ns,
    input logic        sev);
    cis_make_status = {sev, ns, 1'b0, code};
  endfunction

  wire [15:0] op = bus.opcode_word;
  wire        is_read  = (op == `CIS_MEM_READ_REQ);
  wire        is_write = (op == `CIS_MEM_WRITE_REQ);
  wire        is_event = (op == `CIS_EVENT_REQ);
  wire        is_custom = op[`CIS_CUSTOM_BIT];
  wire        is_ack = op[`CIS_ACK_BIT];
  wire [13:0] cmd_value = op[14:1];
  wire        known = is_read | is_write | is_event | (is_custom & bus.custom_en);

  wire [15:0] expect_size = 16'(`CIS_HDR_BYTES + bus.length
                                + {8'h00, bus.frame_ovh});
  // an ack opcode arriving as a command is a disallowed flag combination
  wire bad_header = ((bus.flags & `CIS_FLAG_RSVD_MASK) != 16'h0000)
                    | is_ack | (bus.pkt_size != expect_size);
  wire bad_len = (is_read & (bus.length != `CIS_READ_SCD_BYTES))
                 | (is_write & (bus.length <= `CIS_ADDR_BYTES));
  wire bad_param = bad_len | bus.cond.reserved_nonzero
                   | (is_write & (bus.transaction_seq == 16'h0000));
  wire deny = (is_read & bus.cond.no_read) | (is_write & bus.cond.no_write);
  wire mem_op = is_read | is_write;
  wire ext_on = bus.ext_status[`CIS_EXT_EN_BIT];
  wire [15:0] ext_word = cis_make_status(bus.ext_status[11:0],
                                         bus.ext_status[13:12],
                                         bus.ext_status[14]);

  // most specific code first; generic only when no other error or extended status fits, ahead of the warning
  always_comb begin
    if (bad_header)
      bus.status = `CIS_STATUS_BAD_HEADER;
    else if (!known)
      bus.status = `CIS_STATUS_UNSUPPORTED_CMD;
    else if (bus.cond.busy)
      bus.status = `CIS_STATUS_RECV_OCCUPIED;
    else if (bus.cond.config_forbids)
      bus.status = `CIS_STATUS_CONFIG_FORBIDS;
    else if (bad_param)
      bus.status = `CIS_STATUS_BAD_PARAM;
    else if (mem_op & bus.cond.addr_missing)
      bus.status = `CIS_STATUS_NO_SUCH_ADDR;
    else if (mem_op & bus.cond.misaligned)
      bus.status = `CIS_STATUS_MISALIGNED;
    else if (is_write & bus.cond.read_only)
      bus.status = `CIS_STATUS_READ_ONLY;
    else if (deny)
      bus.status = `CIS_STATUS_NO_ACCESS;
    else if (ext_on)
      bus.status = ext_word;
    else if (bus.cond.generic_fail)
      bus.status = `CIS_STATUS_GENERIC_FAIL;
    else if (bus.cond.warn)
      bus.status = cis_make_status(12'h001, `CIS_NS_DEVICE, 1'b0);
    else
      bus.status = `CIS_STATUS_OK;
  end

  assign bus.ack_opcode = {op[15], cmd_value, 1'b1};
  assign bus.is_ack = is_ack;
  assign bus.is_custom = is_custom;
  assign bus.kind = is_read  ? CIS_KIND_READ  :
                    is_write ? CIS_KIND_WRITE :
                    is_event ? CIS_KIND_EVENT :
                    known    ? CIS_KIND_OTHER : CIS_KIND_NONE;

endmodule // cis_classifier

/* cis_codec.sv */
// top of the command identifier and status word codec
// assumes a synchronous register port and header fields from a packet
// receiver; one clock, asynchronous reset
`timescale 1ns/100ps
`include "cis_defs.svh"

// Summary of operation
// - status words are sixteen bits wide
// - code in low twelve bits, bit12 zero
// - two-bit namespace at bit 13
// - bit 15 set for errors only
// - unknown opcode answers 0x8001
// - bad parameter answers 0x8002
// - missing address answers 0x8003
// - write to read-only answers 0x8004
// - misaligned address answers 0x8005
// - access not permitted answers 0x8006
// - busy receiver answers 0x8007
// - reply timeout reported as 0x800B
// - invalid header answers 0x800E
// - configuration forbids answers 0x800F
// - opcode words are sixteen bits, shared layout
// - bit 0 marks acknowledge, never command
// - bits 1 to 14 hold command value
// - custom opcodes have top bit set
// - read 0x0800, write 0x0802, event 0x0C00
// - replies 0x0801, 0x0803, 0x0805, 0x0C01
// - status occupies header bytes 0 and 1
// - opcode occupies header bytes 2 and 3
module cis_codec
  import cis_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        reply_timeout,
  output logic             ack_valid,
  output logic [15:0]      ack_status,
  output logic [15:0]      ack_opcode,
  output logic [15:0]      ack_seq
);

  cis_cls_if cls_bus ();

  cis_classifier u_classifier (
    .bus (cls_bus)
  );

  logic [15:0]   flags_ff;
  logic [15:0]   opcode_ff;
  logic [15:0]   length_ff;
  logic [15:0]   seq_ff;
  logic [15:0]   pkt_size_ff;
  logic [7:0]    frame_ovh_ff;
  logic          custom_en_ff;
  logic [`CIS_COND_W-1:0] cond_ff;
  logic [15:0]   ext_stat_ff;
  cis_state_type state_ff;
  cis_state_type nxt_state;
  logic [15:0]   status_ff;
  logic [15:0]   nxt_status;
  logic [15:0]   reply_op_ff;
  logic [15:0]   nxt_reply_op;
  logic [15:0]   reply_seq_ff;
  logic          ack_valid_ff;
  logic          timeout_flag_ff;
  logic          is_ack_ff;
  logic          is_custom_ff;
  cis_kind_type  kind_ff;
  logic [31:0]   rdata_ff;

  // address decode, one function used for both strobes
  function automatic logic cis_hit(input logic [7:0] a,
                                   input logic [7:0] reg_off);
    cis_hit = (a == reg_off);
  endfunction

  wire wr_ctrl  = reg_wr & cis_hit(reg_addr, `CIS_REG_CTRL);
  wire wr_hdr0  = reg_wr & cis_hit(reg_addr, `CIS_REG_HDR_IN0);
  wire wr_hdr1  = reg_wr & cis_hit(reg_addr, `CIS_REG_HDR_IN1);
  wire wr_pkt   = reg_wr & cis_hit(reg_addr, `CIS_REG_PKT_INFO);
  wire wr_cond  = reg_wr & cis_hit(reg_addr, `CIS_REG_COND);
  wire wr_ext   = reg_wr & cis_hit(reg_addr, `CIS_REG_EXT_STAT);
  wire go       = wr_ctrl & reg_wdata[`CIS_CTRL_GO];
  wire clr_tmo  = wr_ctrl & reg_wdata[`CIS_CTRL_CLR_TMO];
  wire idle     = (state_ff == CIS_IDLE);
  // header registers are frozen while a command is being judged
  wire hdr_open = idle & ~go;

  assign cls_bus.flags           = flags_ff;
  assign cls_bus.opcode_word     = opcode_ff;
  assign cls_bus.length          = length_ff;
  assign cls_bus.transaction_seq = seq_ff;
  assign cls_bus.pkt_size        = pkt_size_ff;
  assign cls_bus.frame_ovh       = frame_ovh_ff;
  assign cls_bus.custom_en       = custom_en_ff;
  assign cls_bus.cond            = cis_cond_type'(cond_ff);
  assign cls_bus.ext_status      = ext_stat_ff;

  // header and condition capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_ff     <= 16'h0000;
      opcode_ff    <= 16'h0000;
      length_ff    <= 16'h0000;
      seq_ff       <= 16'h0000;
      pkt_size_ff  <= 16'h0000;
      frame_ovh_ff <= 8'h00;
      cond_ff      <= '0;
      ext_stat_ff  <= 16'h0000;
    end else begin
      if (wr_hdr0 && hdr_open) begin
        flags_ff  <= reg_wdata[15:0];
        opcode_ff <= reg_wdata[31:16];
      end
      if (wr_hdr1 && hdr_open) begin
        length_ff <= reg_wdata[15:0];
        seq_ff    <= reg_wdata[31:16];
      end
      if (wr_pkt && hdr_open) begin
        pkt_size_ff  <= reg_wdata[15:0];
        frame_ovh_ff <= reg_wdata[23:16];
      end
      if (wr_cond && hdr_open)
        cond_ff <= reg_wdata[`CIS_COND_W-1:0];
      if (wr_ext && hdr_open)
        ext_stat_ff <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      custom_en_ff <= 1'b0;
    else if (wr_ctrl)
      custom_en_ff <= reg_wdata[`CIS_CTRL_CUSTOM_EN];
  end

  // sequencing: go in idle, judge for one cycle, then announce
  always_comb begin
    case (state_ff)
      CIS_IDLE: nxt_state = go ? CIS_EVAL : CIS_IDLE;
      CIS_EVAL: nxt_state = CIS_DONE;
      CIS_DONE: nxt_state = CIS_IDLE;
      default:  nxt_state = CIS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      state_ff <= CIS_IDLE;
    else
      state_ff <= nxt_state;
  end

  // a judged command wins over a timeout arriving in the same cycle;
  // the timeout still leaves its sticky flag
  wire eval_now = (state_ff == CIS_EVAL);
  wire tmo_now  = reply_timeout & ~eval_now;

  assign nxt_status = eval_now ? cls_bus.status :
                      tmo_now  ? `CIS_STATUS_REPLY_TIMEOUT :
                                 status_ff;
  assign nxt_reply_op = eval_now ? cls_bus.ack_opcode :
                        tmo_now  ? `CIS_PENDING_REP :
                                   reply_op_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_ff    <= `CIS_STATUS_OK;
      reply_op_ff  <= 16'h0000;
      reply_seq_ff <= 16'h0000;
      is_ack_ff    <= 1'b0;
      is_custom_ff <= 1'b0;
      kind_ff      <= CIS_KIND_NONE;
    end else begin
      status_ff   <= nxt_status;
      reply_op_ff <= nxt_reply_op;
      if (eval_now) begin
        reply_seq_ff <= seq_ff;
        is_ack_ff    <= cls_bus.is_ack;
        is_custom_ff <= cls_bus.is_custom;
        kind_ff      <= cls_bus.kind;
      end
    end
  end

  // one-cycle announce, both for judged commands and timeouts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      ack_valid_ff <= 1'b0;
    else
      ack_valid_ff <= eval_now | tmo_now;
  end

  // set wins over clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      timeout_flag_ff <= 1'b0;
    else if (reply_timeout)
      timeout_flag_ff <= 1'b1;
    else if (clr_tmo)
      timeout_flag_ff <= 1'b0;
  end

  // readback; ack header word 0 gives status in bytes 0-1, opcode in 2-3; word 1 gives the sequence in 2-3
  wire [31:0] ack_hdr0 = {reply_op_ff, status_ff};
  wire [31:0] ack_hdr1 = {reply_seq_ff, 16'h0000};
  wire [31:0] stat_w = {status_ff, 8'h00, kind_ff, is_custom_ff,
                        is_ack_ff, timeout_flag_ff, ack_valid_ff};
  wire [31:0] rd_mux =
    cis_hit(reg_addr, `CIS_REG_CTRL)     ?
      {29'h0, custom_en_ff, 2'h0} :
    cis_hit(reg_addr, `CIS_REG_HDR_IN0)  ? {opcode_ff, flags_ff} :
    cis_hit(reg_addr, `CIS_REG_HDR_IN1)  ? {seq_ff, length_ff} :
    cis_hit(reg_addr, `CIS_REG_PKT_INFO) ?
      {8'h00, frame_ovh_ff, pkt_size_ff} :
    cis_hit(reg_addr, `CIS_REG_COND)     ?
      {{(32-`CIS_COND_W){1'b0}}, cond_ff} :
    cis_hit(reg_addr, `CIS_REG_EXT_STAT) ? {16'h0000, ext_stat_ff} :
    cis_hit(reg_addr, `CIS_REG_ACK_HDR0) ? ack_hdr0 :
    cis_hit(reg_addr, `CIS_REG_ACK_HDR1) ? ack_hdr1 :
    cis_hit(reg_addr, `CIS_REG_STAT)     ? stat_w : 32'h0000_0000;

  // data only in the cycle after the read strobe; zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  assign reg_rdata  = rdata_ff;
  assign ack_valid  = ack_valid_ff;
  assign ack_status = status_ff;
  assign ack_opcode = reply_op_ff;
  assign ack_seq    = reply_seq_ff;

endmodule // cis_codec

/* cis_codec_properties.sv */
// concurrent checks on the ports of the codec top
// assumes single clock clk_sys and asynchronous active-high rst
`timescale 1ns/100ps
module cis_codec_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reply_timeout,
  input wire logic        ack_valid,
  input wire logic [15:0] ack_status,
  input wire logic [15:0] ack_opcode,
  input wire logic [15:0] ack_seq
);
  logic        eval_ff;
  logic        done_ff;
  logic [15:0] opc_ff;
  logic [15:0] seq_ff;
  logic        busy;
  logic        go;
  logic        tmo;
  // the codec stays busy two cycles after go: a go or a header write
  // in either cycle is refused, so the shadows skip both
  assign busy = eval_ff || done_ff;
  assign go   = reg_wr && reg_addr == 8'h00 && reg_wdata[0] && !busy;
  assign tmo  = reply_timeout && !eval_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      eval_ff <= 1'b0;
      done_ff <= 1'b0;
      opc_ff  <= 16'h0000;
      seq_ff  <= 16'h0000;
    end else begin
      eval_ff <= go;
      done_ff <= eval_ff;
      if (reg_wr && reg_addr == 8'h04 && !busy)
        opc_ff <= reg_wdata[31:16];
      if (reg_wr && reg_addr == 8'h08 && !busy)
        seq_ff <= reg_wdata[31:16];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_GO_ACK: assert property (go |-> ##2 ack_valid)
    else $error("no ack two cycles after go");
  AST_ACK_OPC: assert property (
    go |-> ##2 ack_opcode == (opc_ff | 16'h0001))
    else $error("reply opcode not command value with bit0 set");
  AST_ACK_SEQ: assert property (go |-> ##2 ack_seq == seq_ff)
    else $error("sequence not echoed");
  AST_TMO_ACK: assert property (tmo |=> ack_valid &&
    ack_status == 16'h800b && ack_opcode == 16'h0805)
    else $error("timeout ack wrong");
  AST_ACK_CAUSE: assert property (
    ack_valid |-> $past(go, 2) || $past(tmo))
    else $error("ack without cause");
  AST_RSVD: assert property (ack_valid |-> !ack_status[12])
    else $error("reserved status bit set");
  AST_SEV: assert property (ack_valid && ack_status[14:13] == 2'h0 &&
    ack_status != 16'h0000 |-> ack_status[15])
    else $error("protocol code without error severity");
  AST_HDR0: assert property (
    reg_rd && reg_addr == 8'h18 ##1 !ack_valid |->
    reg_rdata == {ack_opcode, ack_status})
    else $error("ack header word layout wrong");
  AST_UNMAP: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  cover property (go);
  cover property (tmo);
  cover property (ack_valid && ack_opcode[15]);
endmodule // cis_codec_properties

bind cis_codec cis_codec_properties i_cis_codec_properties (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reply_timeout(reply_timeout),
  .ack_valid(ack_valid), .ack_status(ack_status),
  .ack_opcode(ack_opcode), .ack_seq(ack_seq));

/* cis_host_model.sv */
// host side: drives the register port and the reply timeout pulse
// assumes tasks are entered just after a rising edge of clk_sys
`timescale 1ns/100ps
module cis_host_model (
  input  wire logic  clk_sys,
  output logic [7:0]  reg_addr,
  output logic [31:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic        reply_timeout
);
  initial begin
    reg_addr      = 8'h00;
    reg_wdata     = 32'h0;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reply_timeout = 1'b0;
  end
  // opcode words always travel whole in one 32-bit access
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a);
    reg_addr  <= a;
    reg_wdata <= ~reg_wdata;
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk_sys);
  endtask
  task quiet();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  // only pulsed while the device is idle
  task tmo();
    reply_timeout <= 1'b1;
    @(posedge clk_sys);
    reply_timeout <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // cis_host_model

/* cis_codec_tb.sv */
// self-checking bench: host model drives, a monitor compares acks/reads
// assumes 20 MHz clk_sys and reset held three cycles
`timescale 1ns/100ps
module cis_codec_tb;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        reply_timeout;
  logic        ack_valid;
  logic [15:0] ack_status;
  logic [15:0] ack_opcode;
  logic [15:0] ack_seq;
  logic [48:0] exp_q[$];
  logic [63:0] rd_q[$];
  logic        rd_seen;
  logic [15:0] last_seq;
  integer      errors;
  integer      checks_done;
  integer      seed;

  cis_codec i_cis_codec (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reply_timeout(reply_timeout),
    .ack_valid(ack_valid), .ack_status(ack_status),
    .ack_opcode(ack_opcode), .ack_seq(ack_seq));
  cis_host_model i_cis_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reply_timeout(reply_timeout));

  always #25 clk_sys = ~clk_sys;

  task stop_test();
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check_ack(input logic [48:0] e);
    checks_done++;
    if (ack_status !== e[47:32] || ack_opcode !== e[31:16] ||
        (e[48] && ack_seq !== e[15:0])) begin
      errors++;
      $display("BAD %0t ack %h %h %h", $time, ack_status, ack_opcode, ack_seq);
    end
  endtask
  task check_rd(input logic [63:0] e);
    checks_done++;
    if ((reg_rdata & e[63:32]) !== e[31:0]) begin
      errors++;
      $display("BAD %0t read %h", $time, reg_rdata);
    end
  endtask
  // a missing ack leaves its note queued; the final queue check catches it
  always @(posedge clk_sys) begin
    if (ack_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("BAD %0t unexpected ack", $time);
      end else check_ack(exp_q.pop_front());
    end
    if (rd_seen === 1'b1 && rd_q.size() > 0)
      check_rd(rd_q.pop_front());
    rd_seen <= reg_rd;
  end

  task judge(input logic [15:0] opc, input logic [15:0] flg,
             input logic [15:0] len, input logic zs, input logic [15:0] dpk,
             input logic [9:0] cnd, input logic [15:0] ext, input logic ce,
             input logic [15:0] exp);
    logic [15:0] sq;
    sq = 16'($random(seed));
    sq = zs ? 16'h0000 : (sq | 16'h0001);
    last_seq = sq;
    exp_q.push_back({1'b1, exp, opc | 16'h0001, sq});
    i_cis_host_model.wr(8'h04, {opc, flg});
    i_cis_host_model.wr(8'h08, {sq, len});
    // four bytes of framing overhead; dpk breaks the size on purpose
    i_cis_host_model.wr(8'h0c, {8'h00, 8'h04, 16'h000c + len + dpk});
    i_cis_host_model.wr(8'h10, {22'h0, cnd});
    i_cis_host_model.wr(8'h14, {16'h0, ext});
    i_cis_host_model.wr(8'h00, {29'h0, ce, 2'h1});
    i_cis_host_model.quiet();
    @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    rd_seen = 1'b0;
    errors = 0;
    checks_done = 0;
    seed = 29211;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    judge(16'h0800, 16'h4000, 12, 0, 0, 10'h000, 0, 0, 16'h0000);
    judge(16'h0802, 16'h0000, 12, 0, 0, 10'h000, 0, 0, 16'h0000);
    judge(16'h0c00, 16'h0000, 0, 0, 0, 10'h000, 0, 0, 16'h0000);
    judge(16'h0804, 16'h0000, 12, 0, 0, 10'h000, 0, 0, 16'h8001);
    judge(16'h8010, 16'h0000, 12, 0, 0, 10'h000, 0, 0, 16'h8001);
    judge(16'h8010, 16'h0000, 12, 0, 0, 10'h000, 0, 1, 16'h0000);
    rd_q.push_back({32'hffffffff, 32'h00000088});
    i_cis_host_model.rd(8'h20);
    judge(16'h0800, 16'h0001, 12, 0, 0, 10'h000, 0, 0, 16'h800e);
    judge(16'h0801, 16'h0000, 12, 0, 0, 10'h000, 0, 0, 16'h800e);
    rd_q.push_back({32'hffffffff, 32'h800e0004});
    i_cis_host_model.rd(8'h20);
    judge(16'h0800, 16'h0000, 12, 0, 1, 10'h000, 0, 0, 16'h800e);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h020, 0, 0, 16'h8007);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h040, 0, 0, 16'h800f);
    judge(16'h0800, 16'h0000, 10, 0, 0, 10'h000, 0, 0, 16'h8002);
    judge(16'h0802, 16'h0000, 12, 1, 0, 10'h000, 0, 0, 16'h8002);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h080, 0, 0, 16'h8002);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h001, 0, 0, 16'h8003);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h004, 0, 0, 16'h8005);
    judge(16'h0802, 16'h0000, 12, 0, 0, 10'h002, 0, 0, 16'h8004);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h008, 0, 0, 16'h8006);
    judge(16'h0802, 16'h0000, 12, 0, 0, 10'h010, 0, 0, 16'h8006);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h000, 16'hf123, 0, 16'he123);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h200, 0, 0, 16'h8fff);
    judge(16'h0800, 16'h0000, 12, 0, 0, 10'h100, 0, 0, 16'h4001);
    rd_q.push_back({32'hffffffff, 32'h08014001});
    rd_q.push_back({32'hffffffff, last_seq, 16'h0000});
    rd_q.push_back({32'hffffffff, 32'h0});
    i_cis_host_model.rd(8'h18);
    i_cis_host_model.rd(8'h1c);
    i_cis_host_model.rd(8'h40);
    i_cis_host_model.quiet();
    exp_q.push_back({1'b0, 16'h800b, 16'h0805, 16'h0000});
    i_cis_host_model.tmo();
    rd_q.push_back({32'hffffffff, 32'h800b0012});
    i_cis_host_model.rd(8'h20);
    i_cis_host_model.wr(8'h00, 32'h2);
    rd_q.push_back({32'hffffffff, 32'h800b0010});
    i_cis_host_model.rd(8'h20);
    i_cis_host_model.quiet();
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0 || rd_q.size() != 0) begin
      errors++;
      $display("BAD %0t missing results", $time);
    end
    stop_test();
  end

  initial begin
    #(5000 * 50);
    errors++;
    $display("BAD %0t watchdog", $time);
    stop_test();
  end
endmodule // cis_codec_tb
